//--- core/macirq_defines.svh
/*
  Offsets, field positions, reset values and timing counts for the MAC
  event and PHY management register block.
  Assumes inclusion by bare name from the package and design file.
*/
`ifndef MACIRQ_DEFINES_SVH
`define MACIRQ_DEFINES_SVH

// Register byte offsets
`define MACIRQ_OFF_RX_STATUS    8'h00
`define MACIRQ_OFF_EVENT_STATUS 8'h04
`define MACIRQ_OFF_EVENT_ENABLE 8'h08
`define MACIRQ_OFF_EVENT_DIS    8'h0c
`define MACIRQ_OFF_EVENT_MASK   8'h10
`define MACIRQ_OFF_PHY_MGMT     8'h14
`define MACIRQ_OFF_PAUSE_TIME   8'h18

// Event status bit positions
`define MACIRQ_BIT_MGMT_DONE    0
`define MACIRQ_BIT_RX_COMPLETE  1
`define MACIRQ_BIT_RX_OWNED     2
`define MACIRQ_BIT_TX_OWNED     3
`define MACIRQ_BIT_TX_UNDERRUN  4
`define MACIRQ_BIT_RETRY_LIMIT  5
`define MACIRQ_BIT_TX_EXHAUST   6
`define MACIRQ_BIT_TX_COMPLETE  7
`define MACIRQ_BIT_RX_OVERRUN   10
`define MACIRQ_BIT_BUS_ERROR    11
`define MACIRQ_BIT_PAUSE_RX     12
`define MACIRQ_BIT_PAUSE_ZERO   13
`define MACIRQ_EVENT_VALID      14'h3cff

// Receive status bit positions
`define MACIRQ_RXS_FRAME_RX     1
`define MACIRQ_RXS_OVERRUN      2

// PHY management frame fields
`define MACIRQ_MGMT_SOF_HI      31
`define MACIRQ_MGMT_SOF_LO      30
`define MACIRQ_MGMT_OP_HI       29
`define MACIRQ_MGMT_OP_LO       28
`define MACIRQ_MGMT_REG_HI      22
`define MACIRQ_MGMT_REG_LO      18
`define MACIRQ_MGMT_CODE_HI     17
`define MACIRQ_MGMT_CODE_LO     16
`define MACIRQ_MGMT_DATA_HI     15
`define MACIRQ_MGMT_SOF_OK      2'h1
`define MACIRQ_MGMT_OP_READ     2'h2
`define MACIRQ_MGMT_OP_WRITE    2'h1

// Reset values
`define MACIRQ_RST_EVENT        14'h0000
`define MACIRQ_RST_MASK         14'h3fff
`define MACIRQ_RST_MGMT         32'h0000_0000
`define MACIRQ_RST_PAUSE        16'h0000

// Pause quantum: 512 bit times at 100 Mbit/s is 5120 ns
`define MACIRQ_CLK_PERIOD_NS    100
`define MACIRQ_QUANTUM_NS       5120
`define MACIRQ_QUANTUM_CYC      (`MACIRQ_QUANTUM_NS / `MACIRQ_CLK_PERIOD_NS)

`endif

//--- core/macirq_pkg.sv
/*
  Types for the MAC event and PHY management register block.
  Assumes the defines header is on the include path.
*/
`default_nettype none
`include "macirq_defines.svh"

package macirq_pkg;
  typedef logic [31:0] macirq_word_type;
  typedef logic [13:0] macirq_event_type;
  // Management engine states, Gray along idle->busy->done
  typedef enum logic [1:0] {
    MACIRQ_MG_IDLE = 2'b00,
    MACIRQ_MG_BUSY = 2'b01,
    MACIRQ_MG_DONE = 2'b11
  } macirq_mgmt_state_type;
endpackage

`default_nettype wire

//--- core/macirq_regs.sv
/*
  Event status, enable, disable and mask logic with the receive status
  and PHY management frame registers, behind an AXI4-Lite slave.
  Assumes event inputs are one-cycle pulses synchronous to clock and a
  management shifter outside that handshakes over mgmt_start/mgmt_finish.
*/
`default_nettype none
`include "macirq_defines.svh"

module macirq_regs
  import macirq_pkg::*;
(
  input  wire  logic                      clock,
  input  wire  logic                      rst_b,
  input  wire  logic [7:0]                s_axi_awaddr,
  input  wire  logic                      s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire  macirq_pkg::macirq_word_type s_axi_wdata,
  input  wire  logic [3:0]                s_axi_wstrb,
  input  wire  logic                      s_axi_wvalid,
  output logic                            s_axi_wready,
  output logic [1:0]                      s_axi_bresp,
  output logic                            s_axi_bvalid,
  input  wire  logic                      s_axi_bready,
  input  wire  logic [7:0]                s_axi_araddr,
  input  wire  logic                      s_axi_arvalid,
  output logic                            s_axi_arready,
  output macirq_pkg::macirq_word_type     s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  output logic                            s_axi_rvalid,
  input  wire  logic                      s_axi_rready,
  input  wire  logic                      rx_frame_stored,
  input  wire  logic                      rx_store_failed,
  input  wire  logic                      rx_desc_owned_seen,
  input  wire  logic                      tx_desc_owned_seen,
  input  wire  logic                      tx_data_late,
  input  wire  logic                      tx_used_mid_frame,
  input  wire  logic                      tx_queue_ptr_written,
  input  wire  logic                      tx_retry_limit,
  input  wire  logic                      tx_buffers_out,
  input  wire  logic                      tx_frame_sent,
  input  wire  logic                      dma_bus_error,
  input  wire  logic                      pause_frame_valid,
  input  wire  logic                      pause_load,
  input  wire  logic [15:0]               pause_load_value,
  output logic                            pause_active,
  output logic                            mgmt_start,
  output macirq_pkg::macirq_word_type     mgmt_frame,
  output logic                            mgmt_frame_valid,
  input  wire  logic                      mgmt_finish,
  input  wire  logic [15:0]               mgmt_read_data,
  output logic                            irq
);
  import macirq_pkg::*;

  logic                  aw_held_q;
  logic [7:0]            aw_addr_q;
  logic                  w_held_q;
  macirq_word_type       w_data_q;
  logic [3:0]            w_strb_q;
  logic                  bvalid_q;
  logic [1:0]            bresp_q;
  logic                  rvalid_q;
  logic [1:0]            rresp_q;
  macirq_word_type       rdata_q;
  logic                  wr_fire;
  logic                  rd_fire;
  macirq_word_type       wr_bits;
  logic [2:0]            rx_status_q;
  macirq_event_type      event_q;
  macirq_event_type      event_d;
  macirq_event_type      event_set;
  macirq_event_type      mask_q;
  macirq_word_type       mgmt_q;
  macirq_mgmt_state_type mg_state_q;
  logic [15:0]           pause_q;
  logic [6:0]            quantum_q;
  logic                  pause_zero_pulse;
  logic                  wr_mgmt;
  logic                  rd_event;
  macirq_word_type       rd_value;
  logic                  rd_known;
  logic                  wr_known;
  logic                  wr_rx_status;
  logic                  wr_enable;
  logic                  wr_disable;
  logic [7:0]            rd_addr;
  logic [2:0]            rx_set;
  logic                  pause_step;

  // Handshake outputs and data outputs from flops
  assign s_axi_awready = !aw_held_q && !bvalid_q;
  assign s_axi_wready  = !w_held_q && !bvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rdata   = rdata_q;
  assign wr_fire       = aw_held_q && w_held_q && !bvalid_q;
  assign rd_fire       = s_axi_arvalid && !rvalid_q;

  // Word-aligned read address
  assign rd_addr = {s_axi_araddr[7:2], 2'b00};

  // Byte-lane masked write value
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wr_bits[i*8 +: 8] = w_strb_q[i] ? w_data_q[i*8 +: 8] : 8'h00;
    end
  end

  assign wr_known = (aw_addr_q == `MACIRQ_OFF_RX_STATUS)
                 || (aw_addr_q == `MACIRQ_OFF_EVENT_ENABLE)
                 || (aw_addr_q == `MACIRQ_OFF_EVENT_DIS)
                 || (aw_addr_q == `MACIRQ_OFF_PHY_MGMT)
                 || (aw_addr_q == `MACIRQ_OFF_PAUSE_TIME)
                 || (aw_addr_q == `MACIRQ_OFF_EVENT_STATUS)
                 || (aw_addr_q == `MACIRQ_OFF_EVENT_MASK);

  // Write address held until the write completes
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      aw_held_q <= 1'b0;
      aw_addr_q <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_q <= 1'b1;
      aw_addr_q <= {s_axi_awaddr[7:2], 2'b00};
    end else if (wr_fire) begin
      aw_held_q <= 1'b0;
    end
  end

  // Write data held on its own, either half may come first
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      w_held_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_q <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held_q <= 1'b0;
    end
  end

  // Write response, SLVERR on unmapped address
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      bvalid_q <= 1'b0;
      bresp_q  <= 2'b00;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_known ? 2'b00 : 2'b10;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // Read decode
  always_comb begin
    rd_value = 32'h0000_0000;
    rd_known = 1'b1;
    unique case (rd_addr)
      `MACIRQ_OFF_RX_STATUS:    rd_value = {29'h0, rx_status_q};
      `MACIRQ_OFF_EVENT_STATUS: rd_value = {18'h0, event_q};
      `MACIRQ_OFF_EVENT_MASK:   rd_value = {18'h0, mask_q};
      `MACIRQ_OFF_PHY_MGMT:     rd_value = mgmt_q;
      `MACIRQ_OFF_PAUSE_TIME:   rd_value = {16'h0, pause_q};
      `MACIRQ_OFF_EVENT_ENABLE,
      `MACIRQ_OFF_EVENT_DIS:    rd_value = 32'h0000_0000;
      default:                  rd_known = 1'b0;
    endcase
  end

  // Read data held until rready
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rvalid_q <= 1'b0;
      rresp_q  <= 2'b00;
      rdata_q  <= 32'h0000_0000;
    end else if (rd_fire) begin
      rvalid_q <= 1'b1;
      rresp_q  <= rd_known ? 2'b00 : 2'b10;
      rdata_q  <= rd_value;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign rd_event = rd_fire
    && (rd_addr == `MACIRQ_OFF_EVENT_STATUS);
  assign wr_mgmt  = wr_fire && (aw_addr_q == `MACIRQ_OFF_PHY_MGMT);

  // Write strobes for the clear, enable and disable registers
  assign wr_rx_status = wr_fire && (aw_addr_q == `MACIRQ_OFF_RX_STATUS);
  assign wr_enable    = wr_fire && (aw_addr_q == `MACIRQ_OFF_EVENT_ENABLE);
  assign wr_disable   = wr_fire && (aw_addr_q == `MACIRQ_OFF_EVENT_DIS);

  // Receive status set sources, one per bit
  always_comb begin
    rx_set                       = 3'h0;
    rx_set[0]                    = rx_desc_owned_seen;
    rx_set[`MACIRQ_RXS_FRAME_RX] = rx_frame_stored;
    rx_set[`MACIRQ_RXS_OVERRUN]  = rx_store_failed;
  end

  // Receive status: hardware sets, write-one clears, set wins
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rx_status_q <= 3'h0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (rx_set[i]) begin
          rx_status_q[i] <= 1'b1;
        end else if (wr_rx_status && wr_bits[i]) begin
          rx_status_q[i] <= 1'b0;
        end
      end
    end
  end

  // Event sources per status bit
  always_comb begin
    event_set = 14'h0000;
    event_set[`MACIRQ_BIT_MGMT_DONE]   = mgmt_finish;
    event_set[`MACIRQ_BIT_RX_COMPLETE] = rx_frame_stored;
    event_set[`MACIRQ_BIT_RX_OWNED]    = rx_desc_owned_seen;
    event_set[`MACIRQ_BIT_TX_OWNED]    = tx_desc_owned_seen;
    event_set[`MACIRQ_BIT_TX_UNDERRUN] = tx_data_late
      || tx_used_mid_frame || tx_queue_ptr_written;
    event_set[`MACIRQ_BIT_RETRY_LIMIT] = tx_retry_limit;
    event_set[`MACIRQ_BIT_TX_EXHAUST]  = tx_buffers_out;
    event_set[`MACIRQ_BIT_TX_COMPLETE] = tx_frame_sent;
    event_set[`MACIRQ_BIT_RX_OVERRUN]  = rx_store_failed;
    event_set[`MACIRQ_BIT_BUS_ERROR]   = dma_bus_error;
    event_set[`MACIRQ_BIT_PAUSE_RX]    = pause_frame_valid;
    event_set[`MACIRQ_BIT_PAUSE_ZERO]  = pause_zero_pulse;
  end

  // Clear on read, a simultaneous event survives
  assign event_d = ((rd_event ? 14'h0000 : event_q) | event_set)
                 & `MACIRQ_EVENT_VALID;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      event_q <= `MACIRQ_RST_EVENT;
    end else begin
      event_q <= event_d;
    end
  end

  // Mask state: bit high means masked
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      mask_q <= `MACIRQ_RST_MASK;
    end else if (wr_enable) begin
      mask_q <= mask_q & ~wr_bits[13:0];
    end else if (wr_disable) begin
      mask_q <= mask_q | wr_bits[13:0];
    end
  end

  // Interrupt output from unmasked status flags, not from the raw sources
  assign irq = |(event_q & ~mask_q & `MACIRQ_EVENT_VALID);

  // Start pulse, one cycle per frame accepted while idle
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      mgmt_start <= 1'b0;
    end else begin
      mgmt_start <= wr_mgmt && (mg_state_q == MACIRQ_MG_IDLE);
    end
  end

  // Management frame register and transfer handshake
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      mgmt_q     <= `MACIRQ_RST_MGMT;
      mg_state_q <= MACIRQ_MG_IDLE;
    end else begin
      unique case (mg_state_q)
        MACIRQ_MG_IDLE: begin
          if (wr_mgmt) begin
            for (int i = 0; i < 4; i++) begin
              if (w_strb_q[i]) begin
                mgmt_q[i*8 +: 8] <= w_data_q[i*8 +: 8];
              end
            end
            mg_state_q <= MACIRQ_MG_BUSY;
          end
        end
        MACIRQ_MG_BUSY: begin
          if (mgmt_finish) begin
            if (mgmt_q[`MACIRQ_MGMT_OP_HI:`MACIRQ_MGMT_OP_LO] == `MACIRQ_MGMT_OP_READ) begin
              mgmt_q[`MACIRQ_MGMT_DATA_HI:0] <= mgmt_read_data;
            end
            mg_state_q <= MACIRQ_MG_DONE;
          end
        end
        MACIRQ_MG_DONE: mg_state_q <= MACIRQ_MG_IDLE;
        default:        mg_state_q <= MACIRQ_MG_IDLE;
      endcase
    end
  end

  assign mgmt_frame = mgmt_q;
  // Valid frame needs start field 01 and a known operation
  assign mgmt_frame_valid =
    (mgmt_q[`MACIRQ_MGMT_SOF_HI:`MACIRQ_MGMT_SOF_LO] == `MACIRQ_MGMT_SOF_OK)
    && ((mgmt_q[`MACIRQ_MGMT_OP_HI:`MACIRQ_MGMT_OP_LO] == `MACIRQ_MGMT_OP_READ)
     || (mgmt_q[`MACIRQ_MGMT_OP_HI:`MACIRQ_MGMT_OP_LO] == `MACIRQ_MGMT_OP_WRITE));

  // Quantum complete while the counter runs
  assign pause_step = (pause_q != 16'h0000)
                   && (quantum_q == 7'(`MACIRQ_QUANTUM_CYC - 1));

  // Pause counter, one step per 51 clock cycles (5100 ns)
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pause_q   <= `MACIRQ_RST_PAUSE;
      quantum_q <= 7'h00;
    end else begin
      if (pause_load) begin
        pause_q   <= pause_load_value;
        quantum_q <= 7'h00;
      end else if (pause_q != 16'h0000) begin
        if (pause_step) begin
          quantum_q <= 7'h00;
          pause_q   <= pause_q - 16'h0001;
        end else begin
          quantum_q <= quantum_q + 7'h01;
        end
      end
    end
  end

  // Zero event when the last step empties the counter
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pause_zero_pulse <= 1'b0;
    end else begin
      pause_zero_pulse <= !pause_load && pause_step && (pause_q == 16'h0001);
    end
  end

  assign pause_active = (pause_q != 16'h0000);

endmodule

`default_nettype wire

//--- verification/macirq_regs_sva.sv
/* Checker for the event and management register block ports.
   Assumes a bind from the bench top onto macirq_regs. */
`default_nettype none
module macirq_regs_sva
  import macirq_pkg::*;
(
  input wire logic                        clock,
  input wire logic                        rst_b,
  input wire logic                        s_axi_wvalid,
  input wire logic                        s_axi_wready,
  input wire logic                        s_axi_bvalid,
  input wire logic                        s_axi_bready,
  input wire logic                        s_axi_arvalid,
  input wire logic                        s_axi_arready,
  input wire logic                        s_axi_rvalid,
  input wire logic                        pause_load,
  input wire logic [15:0]                 pause_load_value,
  input wire logic                        pause_active,
  input wire logic                        mgmt_start,
  input wire macirq_pkg::macirq_word_type mgmt_frame,
  input wire logic                        mgmt_frame_valid,
  input wire logic                        mgmt_finish,
  input wire logic [15:0]                 mgmt_read_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] wt_q;
  // Recent write-data takes
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) wt_q <= 3'h0;
    else wt_q <= {wt_q[1:0], s_axi_wvalid && s_axi_wready};
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  // Bus answers
  resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  // Management frame handling and pause length
  start_once_a: assert property (mgmt_start |=> !mgmt_start)
    else $error("start longer than one cycle");
  start_cause_a: assert property (mgmt_start |-> |wt_q)
    else $error("start without a write");
  frame_valid_a: assert property (
    mgmt_frame_valid == (mgmt_frame[31:28] inside {4'h5, 4'h6}))
    else $error("frame valid wrong");
  frame_change_a: assert property (
    $changed(mgmt_frame) |-> |wt_q || $past(mgmt_finish))
    else $error("frame changed without cause");
  read_data_a: assert property (
    mgmt_finish && mgmt_frame[29:28] == 2'h2 |=> mgmt_frame[15:0] == $past(mgmt_read_data))
    else $error("read data not stored");
  pause_step_a: assert property (
    pause_load && pause_load_value == 16'h2 |=> pause_active[*8] ##[40:100] !pause_active)
    else $error("pause length wrong");
endmodule
`default_nettype wire

//--- verification/macirq_phy_model.sv
/* Far-side model: management shifter with a PHY register file.
   Assumes frames arrive as mgmt_start pulses. */
`default_nettype none
module macirq_phy_model
  import macirq_pkg::*;
(
  input  wire logic                        clock,
  input  wire logic                        rst_b,
  input  wire logic                        slow,
  input  wire logic                        mgmt_start,
  input  wire macirq_pkg::macirq_word_type mgmt_frame,
  output logic                             mgmt_finish,
  output logic [15:0]                      mgmt_read_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0]     phy_q [32];
  macirq_word_type frame_q;
  int              wait_q;
  // Known PHY register pattern
  initial foreach (phy_q[i]) phy_q[i] = 16'h5a00 + 16'(i);
  // Finish each frame after a short or long delay
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wait_q <= 0;
      mgmt_finish <= 1'b0;
      mgmt_read_data <= 16'h0000;
    end else begin
      mgmt_finish <= 1'b0;
      mgmt_read_data <= ~mgmt_read_data; // Not held outside finish
      wait_q <= wait_q > 0 ? wait_q - 1 : 0;
      if (mgmt_start) begin
        frame_q <= mgmt_frame;
        wait_q <= slow ? 20 : 2;
      end
      if (wait_q == 1) begin
        mgmt_finish <= 1'b1;
        if (frame_q[29:28] == 2'h2) mgmt_read_data <= phy_q[frame_q[22:18]];
        if (frame_q[29:28] == 2'h1) phy_q[frame_q[22:18]] <= frame_q[15:0];
      end
    end
  end
endmodule
`default_nettype wire

//--- verification/macirq_regs_tb.sv
/* Bench for macirq_regs: bus master, event pulses, PHY model.
   Assumes package, checker and model compiled first. */
`default_nettype none
module macirq_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import macirq_pkg::*;
  logic clock = 1'b0, rst_b = 1'b0, slow = 1'b0, pause_load = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic [11:0] ev = 12'h000;
  logic [15:0] pause_load_value = 16'h0000, mgmt_read_data;
  macirq_word_type s_axi_wdata = 32'h0, s_axi_rdata, mgmt_frame, rdat;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic pause_active, mgmt_start, mgmt_frame_valid, mgmt_finish, irq;
  int err_count = 0, comparisons = 0, cycles = 0, seed = 6168;
  macirq_regs u_macirq_regs (
    .clock, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .rx_frame_stored(ev[0]), .rx_store_failed(ev[1]),
    .rx_desc_owned_seen(ev[2]), .tx_desc_owned_seen(ev[3]), .tx_data_late(ev[4]),
    .tx_used_mid_frame(ev[5]), .tx_queue_ptr_written(ev[6]), .tx_retry_limit(ev[7]),
    .tx_buffers_out(ev[8]), .tx_frame_sent(ev[9]), .dma_bus_error(ev[10]),
    .pause_frame_valid(ev[11]), .pause_load, .pause_load_value, .pause_active,
    .mgmt_start, .mgmt_frame, .mgmt_frame_valid, .mgmt_finish, .mgmt_read_data, .irq);
  macirq_phy_model u_macirq_phy_model (.clock, .rst_b, .slow, .mgmt_start, .mgmt_frame,
    .mgmt_finish, .mgmt_read_data);
  // Clock and hang limit
  always #50 clock = ~clock;
  always @(posedge clock) begin
    cycles++;
    if (cycles == 30000) begin
      err_count++;
      give_verdict();
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, e);
    comparisons++;
    if (seen !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, e, seen);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Bus write, response code left in resp
  task automatic wr(input logic [7:0] a, input macirq_word_type d);
    logic aw_t, w_t;
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(negedge clock);
      aw_t = s_axi_awvalid && s_axi_awready;
      w_t = s_axi_wvalid && s_axi_wready;
      @(posedge clock);
      if (aw_t) s_axi_awvalid <= 1'b0;
      if (w_t) s_axi_wvalid <= 1'b0;
    end while (s_axi_awvalid && !aw_t || s_axi_wvalid && !w_t);
    // Response left waiting a cycle before bready rises
    do begin
      @(negedge clock);
    end while (!s_axi_bvalid);
    @(posedge clock);
    s_axi_bready <= 1'b1;
    @(negedge clock);
    resp = s_axi_bresp;
    @(posedge clock);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output macirq_word_type d, output logic [1:0] r);
    logic ar_t;
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge clock);
      ar_t = s_axi_arready;
      @(posedge clock);
    end while (!ar_t);
    s_axi_arvalid <= 1'b0;
    do begin
      @(negedge clock);
      d = s_axi_rdata;
      r = s_axi_rresp;
    end while (!s_axi_rvalid);
    @(posedge clock);
    s_axi_rready <= 1'b0;
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] m, e);
    rd(a, rdat, resp);
    chk(nm, rdat & m, e);
  endtask
  task automatic pulse(input int i);
    @(posedge clock);
    ev[i] <= 1'b1;
    @(posedge clock);
    ev[i] <= 1'b0;
  endtask
  task automatic wait_done();
    rdat = 32'h0;
    for (int n = 0; n < 40 && !rdat[0]; n++) rd(8'h04, rdat, resp);
    chk("mgmt done", rdat[0], 1'b1);
  endtask
  // Status bit set by each event input
  function automatic int ev_bit(input int i);
    int tbl [12] = '{1, 10, 2, 3, 4, 4, 4, 5, 6, 7, 11, 12};
    return tbl[i];
  endfunction
  function automatic macirq_word_type frm(input logic [1:0] op, input logic [4:0] ra,
    input logic [15:0] d);
    return {2'h1, op, 5'h01, ra, 2'h2, d};
  endfunction
  // Main sequence
  initial begin
    int i, k;
    logic [13:0] m, en, di;
    logic [4:0] ra;
    logic [15:0] dv;
    repeat (4) @(posedge clock);
    rst_b <= 1'b1;
    rchk("mask reset", 8'h10, 32'h3cff, 32'h3cff);
    wr(8'hfc, 32'h1);
    chk("unmapped write", resp, 2'h2);
    rd(8'hfc, rdat, resp);
    chk("unmapped read", {rdat[29:0], resp}, 32'h2);
    m = 14'h3fff;
    for (k = 0; k < 6; k++) begin
      en = 14'($random(seed));
      di = 14'($random(seed)) & 14'h0f0f;
      wr(8'h08, {18'h0, en});
      wr(8'h0c, {18'h0, di});
      wr(8'h10, 32'h0);
      m = (m & ~en) | di;
      rchk("mask", 8'h10, 32'h3cff, {18'h0, m & 14'h3cff});
    end
    $display("test mask done");
    wr(8'h0c, 32'h3fff);
    wr(8'h08, 32'h80);
    wr(8'h04, 32'hffffffff);
    pulse(9);
    @(negedge clock);
    chk("irq set", irq, 1'b1);
    rchk("tx complete", 8'h04, 32'hffffffff, 32'h80);
    @(negedge clock);
    chk("irq clear", irq, 1'b0);
    pulse(3);
    @(negedge clock);
    chk("irq masked", irq, 1'b0);
    for (i = 0; i < 2; i++) begin
      pulse(i);
      wr(8'h00, 32'h0);
      rchk("rx kept", 8'h00, 32'h6, 32'h2 << i);
      wr(8'h00, 32'h6);
      wr(8'h00, 32'h6);
      rchk("rx cleared", 8'h00, 32'h6, 32'h0);
    end
    rd(8'h04, rdat, resp);
    for (i = 0; i < 12; i++) begin
      pulse(i);
      rd(8'h04, rdat, resp);
      chk("ev", rdat, 32'h1 << ev_bit(i));
      rchk("read clears", 8'h04, 32'hffffffff, 32'h0);
    end
    $display("test events done");
    for (k = 0; k < 2; k++) begin
      slow <= k[0];
      ra = 5'($random(seed));
      dv = 16'($random(seed));
      wr(8'h14, frm(2'h1, ra, dv));
      wait_done();
      rchk("mgmt frame", 8'h14, 32'hffffffff, frm(2'h1, ra, dv));
      wr(8'h14, frm(2'h2, ra, ~dv));
      wait_done();
      rchk("mgmt read", 8'h14, 32'hffffffff, frm(2'h2, ra, dv));
    end
    $display("test management done");
    @(posedge clock);
    pause_load_value <= 16'h2;
    pause_load <= 1'b1;
    @(posedge clock);
    pause_load <= 1'b0;
    @(negedge clock);
    for (k = 0; k < 200 && pause_active !== 1'b0; k++) @(negedge clock);
    // Two steps of 51 cycles each
    chk("pause length", k, 32'd102);
    rd(8'h04, rdat, resp);
    chk("pause zero", rdat[13], 1'b1);
    $display("test pause done");
    give_verdict();
  end
endmodule
bind macirq_regs macirq_regs_sva u_macirq_regs_sva (.clock, .rst_b, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .pause_load, .pause_load_value, .pause_active, .mgmt_start,
  .mgmt_frame, .mgmt_frame_valid, .mgmt_finish, .mgmt_read_data);
`default_nettype wire
